// ===== hw/ebme_pkg.sv
// Package of constants and types for the external bus and mode entry block
// Functional notes
// [R01] Reset pin high two machine cycles resets
// [R02] Fetch strobe falling after ten-cycle reset: host mode
// [R03] No fetch strobe fall during reset: normal mode
// [R04] Internal code execution keeps fetch strobe high
// [R05] External code: two fetch pulses, one skipped
// [R06] Code select low fetches off-chip, high on-chip
// [R07] Lock level 4 forces on-chip code only
// [R08] Latch strobe marks low address byte
// [R09] Latch strobe runs at one sixth clock
// [R10] External data access omits one latch pulse
// [R11] Latch-strobe-off bit stops driving the strobe; the code still drives it while code is external or a data move goes off chip
// [R12] Latch strobe pin is programming pulse input
// [R13] Pointer high byte upper, low byte multiplexed
// [R14] Read strobe P3.7, write strobe P3.6
// [R15] Select bit 0: strobes only from 0300H
// [R16] Select bit 1: strobes on every move
// [R17] Byte-pointer moves reach expanded RAM 0-0FFH only
// [R18] Host supplies control and address through port 3; the block has no port 3 host inputs
// [R19] Read and write strobes never together
package ebme_pkg;

  // ----------------------------------------------------------------
  // Register offsets and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] PTR_LOW_OFS = 8'h82;
  localparam logic [7:0] PTR_HIGH_OFS = 8'h83;
  localparam logic [7:0] AUX_CTRL_OFS = 8'h8E;
  localparam logic [7:0] AUX_CTRL_TWO_OFS = 8'hA2;
  localparam int LATCH_OFF_BIT = 0;
  localparam int XDATA_SEL_BIT = 1;
  localparam int PTR_SEL_BIT = 0;
  localparam int GP_FLAG_BIT = 3;
  localparam int ZERO_BIT = 2;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] AUX_RESET = 8'h00;
  localparam logic [7:0] AUX_TWO_MASK = 8'h09;

  // ----------------------------------------------------------------
  // Timing counts, in oscillator clocks and machine cycles
  // ----------------------------------------------------------------
  localparam int MC_CLKS = 12;
  localparam int HALF_CLKS = MC_CLKS / 2;
  localparam int RESET_MC = 2;
  localparam int HOST_MC = 10;
  localparam logic [7:0] RESET_CLKS = 8'(RESET_MC * MC_CLKS);
  localparam logic [7:0] HOST_CLKS = 8'(HOST_MC * MC_CLKS);
  localparam logic [3:0] LAST_PHASE = 4'(MC_CLKS - 1);
  localparam logic [15:0] XDATA_EXT_BASE = 16'h0300;

  // Pin synchroniser lanes and their idle levels
  localparam int PIN_RST = 0;
  localparam int PIN_FETCH = 1;
  localparam int PIN_CODE_SEL = 2;
  localparam int PIN_PROGRAM_PULSE_N = 3;
  localparam logic [3:0] PIN_IDLE = 4'b1110;

  // Operating modes
  typedef enum logic [2:0] {
    ST_HOLD = 3'b001,
    ST_RUN = 3'b010,
    ST_HOST = 3'b100
  } ebme_mode_t;

endpackage

// ===== hw/ebme_pin_sync.sv
// Three-stage pin synchroniser with agreement filter, one lane per bit
`timescale 1ns/1ps
`default_nettype none
module ebme_pin_sync #(
  parameter int WIDTH = 4,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Raw pins and filtered levels
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] level
);

  // ----------------------------------------------------------------
  // Per-lane stages
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : lane
      logic s1;
      logic s2;
      logic s3;
      // Stage one feeds stage two only, to keep metastability contained
      always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
          s1 <= INIT[g];
          s2 <= INIT[g];
          s3 <= INIT[g];
          level[g] <= INIT[g];
        end else begin
          s1 <= pin[g];
          s2 <= s1;
          s3 <= s2;
          if (s2 == s3) begin
            level[g] <= s3;
          end
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// ===== hw/ebme_bus_ctrl.sv
// External bus strobes, data-move decode and reset-time mode entry
`timescale 1ns/1ps
`default_nettype none
module ebme_bus_ctrl
  import ebme_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Device pins
  input wire logic rst_pin,
  input wire logic external_code_select_n,
  input wire logic code_fetch_strobe_n_i,
  output logic code_fetch_strobe_n_o,
  output logic code_fetch_strobe_n_oe,
  input wire logic latch_strobe_i,
  output logic latch_strobe_o,
  output logic latch_strobe_oe,
  output logic rd_strobe_n,
  output logic wr_strobe_n,
  output logic [7:0] addr_hi,
  input wire logic [7:0] mux_bus_i,
  output logic [7:0] mux_bus_o,
  output logic mux_bus_oe,
  // Special function register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  output logic sfr_hit,
  // Core requests
  input wire logic security_lock4,
  input wire logic [15:0] pc,
  input wire logic xmove_req,
  input wire logic xmove_write,
  input wire logic xmove_use_wide_data_pointer,
  input wire logic [7:0] xmove_ri_addr,
  input wire logic [7:0] xmove_wdata,
  output logic xmove_done,
  output logic [7:0] xmove_rdata,
  output logic [7:0] fetch_data,
  output logic fetch_valid,
  // Expanded on-chip RAM side
  output logic expanded_onchip_ram_req,
  output logic expanded_onchip_ram_we,
  output logic [9:0] expanded_onchip_ram_addr,
  output logic [7:0] expanded_onchip_ram_wdata,
  // Mode status
  output logic device_reset,
  output logic host_mode,
  output logic program_pulse_n
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] pin_level;
  ebme_pin_sync #(.WIDTH(4), .INIT(PIN_IDLE)) ebme_pin_sync_i (
    .core_clk(core_clk),
    .rstn(rstn),
    .pin({latch_strobe_i, external_code_select_n, code_fetch_strobe_n_i, rst_pin}),
    .level(pin_level)
  );

  logic rst_f;
  logic fetch_pin_prev;
  logic fetch_fall;
  assign rst_f = pin_level[PIN_RST];
  assign fetch_fall = fetch_pin_prev && !pin_level[PIN_FETCH];

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] ptr_low;
  logic [7:0] ptr_high;
  logic [7:0] aux_ctrl;
  logic [7:0] aux_ctrl_two;
  logic latch_off;
  logic xdata_sel;
  assign latch_off = aux_ctrl[LATCH_OFF_BIT];
  assign xdata_sel = aux_ctrl[XDATA_SEL_BIT];

  // Software writes; reserved bits of the second control register stay zero
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ptr_low <= PTR_RESET;
      ptr_high <= PTR_RESET;
      aux_ctrl <= AUX_RESET;
      aux_ctrl_two <= AUX_RESET;
    end else if (sfr_wr) begin
      if (sfr_addr == PTR_LOW_OFS) begin
        ptr_low <= sfr_wdata;
      end else if (sfr_addr == PTR_HIGH_OFS) begin
        ptr_high <= sfr_wdata;
      end else if (sfr_addr == AUX_CTRL_OFS) begin
        aux_ctrl <= {6'h00, sfr_wdata[XDATA_SEL_BIT], sfr_wdata[LATCH_OFF_BIT]};
      end else if (sfr_addr == AUX_CTRL_TWO_OFS) begin
        aux_ctrl_two <= sfr_wdata & AUX_TWO_MASK;
      end
    end
  end

  // Read data is registered, so it shows one clock after the strobe
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sfr_rdata <= 8'h00;
      sfr_hit <= 1'b0;
    end else if (sfr_rd) begin
      sfr_hit <= 1'b1;
      if (sfr_addr == PTR_LOW_OFS) begin
        sfr_rdata <= ptr_low;
      end else if (sfr_addr == PTR_HIGH_OFS) begin
        sfr_rdata <= ptr_high;
      end else if (sfr_addr == AUX_CTRL_OFS) begin
        sfr_rdata <= aux_ctrl;
      end else if (sfr_addr == AUX_CTRL_TWO_OFS) begin
        sfr_rdata <= aux_ctrl_two;
      end else begin
        sfr_rdata <= 8'h00;
        sfr_hit <= 1'b0;
      end
    end else begin
      sfr_hit <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Reset hold counting and mode entry
  // ----------------------------------------------------------------
  ebme_mode_t mode;
  logic [7:0] rst_cnt;
  logic host_armed;

  // Saturating count of clocks with the reset pin high
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rst_cnt <= 8'h00;
      fetch_pin_prev <= 1'b1;
    end else begin
      fetch_pin_prev <= pin_level[PIN_FETCH];
      if (!rst_f) begin
        rst_cnt <= 8'h00;
      end else if (rst_cnt != 8'hFF) begin
        rst_cnt <= rst_cnt + 8'h01;
      end
    end
  end

  // Short glitches on the reset pin never reach the core
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      device_reset <= 1'b0;
    end else begin
      device_reset <= rst_f && (rst_cnt >= RESET_CLKS); // [R01]
    end
  end

  // Host entry needs the strobe fall after the long hold
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      host_armed <= 1'b0;
    end else if (mode != ST_HOLD) begin
      host_armed <= 1'b0;
    end else if (rst_f && rst_cnt > HOST_CLKS && fetch_fall) begin
      host_armed <= 1'b1; // [R02]
    end
  end

  // Mode machine
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      mode <= ST_HOLD;
    end else begin
      case (mode)
        ST_HOLD: begin
          if (!rst_f) begin
            mode <= host_armed ? ST_HOST : ST_RUN; // [R02] [R03]
          end
        end
        ST_RUN: begin
          if (device_reset) begin
            mode <= ST_HOLD;
          end
        end
        ST_HOST: begin
          if (device_reset) begin
            mode <= ST_HOLD;
          end
        end
        default: begin
          mode <= ST_HOLD;
        end
      endcase
    end
  end

  // Host mode takes the latch pin as the programming pulse input
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      host_mode <= 1'b0;
      program_pulse_n <= 1'b1;
    end else begin
      host_mode <= (mode == ST_HOST);
      program_pulse_n <= (mode == ST_HOST) ? pin_level[PIN_PROGRAM_PULSE_N] : 1'b1; // [R12]
    end
  end

  // ----------------------------------------------------------------
  // Machine cycle phase and data-move sequencing
  // ----------------------------------------------------------------
  logic [3:0] phase;
  logic run;
  logic code_ext;
  logic xact;
  logic xact_ext;
  logic xact_write;
  logic [15:0] xact_addr;
  logic [7:0] xact_wdata;
  logic [15:0] wide_data_pointer;
  logic accept;
  logic next_ext;
  assign run = (mode == ST_RUN);
  assign wide_data_pointer = {ptr_high, ptr_low};
  // Lock level 4 overrides the code select pin
  assign code_ext = !pin_level[PIN_CODE_SEL] && !security_lock4; // [R06] [R07]
  assign accept = run && xmove_req && !xact && (phase == LAST_PHASE);
  // Below 0300H or by byte pointer the move stays on chip unless selected off
  assign next_ext = xdata_sel || (xmove_use_wide_data_pointer && wide_data_pointer >= XDATA_EXT_BASE); // [R15] [R16]

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      phase <= 4'h0;
    end else if (!run || phase == LAST_PHASE) begin
      phase <= 4'h0;
    end else begin
      phase <= phase + 4'h1;
    end
  end

  // One move occupies exactly one machine cycle
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      xact <= 1'b0;
      xact_ext <= 1'b0;
      xact_write <= 1'b0;
      xact_addr <= 16'h0000;
      xact_wdata <= 8'h00;
    end else if (accept) begin
      xact <= 1'b1;
      xact_ext <= next_ext;
      xact_write <= xmove_write;
      xact_addr <= xmove_use_wide_data_pointer ? wide_data_pointer : {8'h00, xmove_ri_addr}; // [R13]
      xact_wdata <= xmove_wdata;
    end else if (!run || phase == LAST_PHASE) begin
      xact <= 1'b0;
      xact_ext <= 1'b0;
    end
  end

  // On-chip moves go to the expanded RAM; byte pointer reaches 0-0FFH
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      expanded_onchip_ram_req <= 1'b0;
      expanded_onchip_ram_we <= 1'b0;
      expanded_onchip_ram_addr <= 10'h000;
      expanded_onchip_ram_wdata <= 8'h00;
    end else begin
      expanded_onchip_ram_req <= accept && !next_ext;
      if (accept && !next_ext) begin
        expanded_onchip_ram_we <= xmove_write;
        expanded_onchip_ram_addr <= xmove_use_wide_data_pointer ? wide_data_pointer[9:0] : {2'b00, xmove_ri_addr}; // [R17]
        expanded_onchip_ram_wdata <= xmove_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin strobes, driven one clock behind the phase that selects them
  // ----------------------------------------------------------------
  logic half1;
  logic ale_win;
  logic fetch_win;
  logic data_win;
  logic ale_need;
  assign half1 = (phase >= 4'(HALF_CLKS));
  assign ale_win = (phase == 4'h0) || (phase == 4'h1) || (phase == 4'h6) || (phase == 4'h7);
  assign fetch_win = (phase >= 4'h3 && phase <= 4'h5) || (phase >= 4'h9);
  assign data_win = (phase >= 4'h3 && phase <= 4'h5);
  // With the latch off, the strobe still marks real external accesses
  assign ale_need = !latch_off || code_ext || xact_ext; // [R11]

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      latch_strobe_o <= 1'b0;
      latch_strobe_oe <= 1'b0;
      code_fetch_strobe_n_o <= 1'b1;
      code_fetch_strobe_n_oe <= 1'b0;
    end else begin
      latch_strobe_oe <= run && ale_need; // [R11]
      // Second latch pulse is dropped in a data cycle
      latch_strobe_o <= run && ale_need && ale_win && !(xact_ext && half1); // [R08] [R09] [R10]
      code_fetch_strobe_n_oe <= run;
      // First fetch pulse is dropped in a data cycle
      code_fetch_strobe_n_o <= !(run && code_ext && fetch_win && !(xact_ext && !half1)); // [R04] [R05]
    end
  end

  // Read on P3.7, write on P3.6; only one can be low
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rd_strobe_n <= 1'b1;
      wr_strobe_n <= 1'b1;
    end else begin
      rd_strobe_n <= !(run && xact_ext && !xact_write && data_win); // [R14] [R19]
      wr_strobe_n <= !(run && xact_ext && xact_write && data_win); // [R14] [R19]
    end
  end

  // Address and multiplexed data lanes
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      addr_hi <= 8'h00;
      mux_bus_o <= 8'h00;
      mux_bus_oe <= 1'b0;
    end else begin
      addr_hi <= (xact_ext && !half1) ? xact_addr[15:8] : pc[15:8]; // [R13]
      if (run && ale_win && (code_ext || xact_ext)) begin
        mux_bus_o <= (xact_ext && !half1) ? xact_addr[7:0] : pc[7:0]; // [R08] [R13]
        mux_bus_oe <= 1'b1;
      end else if (run && xact_ext && xact_write && !half1 && phase >= 4'h2) begin
        mux_bus_o <= xact_wdata;
        mux_bus_oe <= 1'b1;
      end else begin
        mux_bus_oe <= 1'b0;
      end
    end
  end

  // Capture returned bytes at the close of each strobe window
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      xmove_rdata <= 8'h00;
      fetch_data <= 8'h00;
      fetch_valid <= 1'b0;
      xmove_done <= 1'b0;
    end else begin
      if (!rd_strobe_n && phase == 4'h6) begin
        xmove_rdata <= mux_bus_i;
      end
      fetch_valid <= !code_fetch_strobe_n_o && (phase == 4'h6 || phase == 4'h0);
      if (!code_fetch_strobe_n_o && (phase == 4'h6 || phase == 4'h0)) begin
        fetch_data <= mux_bus_i;
      end
      xmove_done <= xact && phase == LAST_PHASE;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence ale_gap_s;
    latch_strobe_o ##1 (!latch_strobe_o) [*4] ##1 (latch_strobe_o || latch_off || !run);
  endsequence

  a_reset_hold: assert property (@(posedge core_clk) disable iff (!rstn) // [R01]
    $rose(device_reset) |-> $past(rst_cnt) >= RESET_CLKS && $past(rst_f))
    else $error("core reset without two machine cycles of pin high");
  a_host_arm: assert property (@(posedge core_clk) disable iff (!rstn) // [R02]
    $rose(host_armed) |-> $past(rst_cnt) > HOST_CLKS && $past(fetch_fall))
    else $error("host mode armed too early");
  a_normal_entry: assert property (@(posedge core_clk) disable iff (!rstn) // [R03]
    (mode == ST_HOLD && !rst_f && !host_armed) |=> mode == ST_RUN)
    else $error("normal mode not entered");
  a_fetch_idle: assert property (@(posedge core_clk) disable iff (!rstn) // [R04]
    (!code_ext && $past(!code_ext)) |-> code_fetch_strobe_n_o)
    else $error("fetch strobe active while on-chip");
  a_fetch_pulse: assert property (@(posedge core_clk) disable iff (!rstn) // [R05]
    (run && code_ext && !xact_ext && phase == 4'h9) |=> !code_fetch_strobe_n_o)
    else $error("fetch pulse missing");
  a_lock_only: assert property (@(posedge core_clk) disable iff (!rstn) // [R07]
    (security_lock4 && $past(security_lock4)) |-> code_fetch_strobe_n_o)
    else $error("lock level ignored");
  a_ale_rate: assert property (@(posedge core_clk) disable iff (!rstn) // [R09]
    (run && !latch_off && !$past(latch_off) && !xact_ext && phase == 4'h2 && $past(run, 3)) |-> ale_gap_s)
    else $error("latch strobe rate wrong");
  a_ale_skip: assert property (@(posedge core_clk) disable iff (!rstn) // [R10]
    (xact_ext && phase == 4'h8) |-> !latch_strobe_o)
    else $error("latch pulse not skipped");
  a_ale_off: assert property (@(posedge core_clk) disable iff (!rstn) // [R11]
    (latch_off && !code_ext && !xact_ext) |=> !latch_strobe_o)
    else $error("latch strobe driven while off");
  a_low_idle: assert property (@(posedge core_clk) disable iff (!rstn) // [R15]
    (accept && !xdata_sel && (!xmove_use_wide_data_pointer || wide_data_pointer < XDATA_EXT_BASE)) |=> (!xact_ext && expanded_onchip_ram_req))
    else $error("on-chip move reached pins");
  a_sel_ext: assert property (@(posedge core_clk) disable iff (!rstn) // [R16]
    (accept && xdata_sel) |-> ##5 (!rd_strobe_n || !wr_strobe_n))
    else $error("strobe missing with off-chip select");
  a_strobe_excl: assert property (@(posedge core_clk) disable iff (!rstn) // [R19]
    !(!rd_strobe_n && !wr_strobe_n))
    else $error("read and write strobes together");

endmodule
`default_nettype wire

// ===== sim/ebme_ext_mem.sv
// Behavioural external data and code memory on the multiplexed bus
`timescale 1ns/1ps
`default_nettype none
module ebme_ext_mem (
  // Clock
  input wire logic core_clk,
  // Strobes and bus from the device
  input wire logic latch_strobe_o,
  input wire logic rd_strobe_n,
  input wire logic wr_strobe_n,
  input wire logic code_fetch_strobe_n_o,
  input wire logic [7:0] mux_bus_o,
  input wire logic mux_bus_oe,
  // Data returned to the device
  output logic [7:0] mem_drive
);
  logic [7:0] mem [256];
  logic [7:0] low_addr = 8'h00;
  logic [7:0] last = 8'h00;

  // Known contents: each byte is its low address folded with a constant
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'hA5;
  end

  // Low address captured while the latch strobe is high
  always @(posedge core_clk) begin
    if (latch_strobe_o) low_addr <= mux_bus_o;
  end

  // Write data taken while the write strobe is low and the bus driven
  always @(posedge core_clk) begin
    if (!wr_strobe_n && mux_bus_oe) mem[low_addr] <= mux_bus_o;
    last <= mem_drive;
  end

  // Released bus toggles every cycle so a stale value never passes
  always_comb begin
    if (!rd_strobe_n || !code_fetch_strobe_n_o) mem_drive = mem[low_addr];
    else mem_drive = ~last;
  end
endmodule
`default_nettype wire

// ===== sim/external_bus_and_mode_entry_bench.sv
// Self-checking bench for the external bus and mode entry block
`timescale 1ns/1ps
`default_nettype none
module external_bus_and_mode_entry_bench;
  import ebme_pkg::*;
  // --------------------
  // Stimulus and wires
  // --------------------
  logic core_clk = 1'b0, rstn = 1'b0, rst_pin = 1'b0, code_sel_n = 1'b1, lock4 = 1'b0;
  logic fetch_drv = 1'b1, program_pulse_n_drv = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, ri = 8'h00, wdata = 8'h00, w;
  logic [15:0] pc = 16'h0000;
  logic req = 1'b0, wr = 1'b0, dp = 1'b0, p_lat = 1'b0, p_fet = 1'b1;
  wire logic fet_o, fet_oe, lat_o, lat_oe, rd_n, wr_n, mux_oe, done, hit, expanded_onchip_ram_req, dev_rst, host, program_pulse_n_n;
  wire logic [7:0] addr_hi, mux_o, mem_drive, rdata, xrdata;
  wire logic [9:0] expanded_onchip_ram_addr;
  wire logic fv, ewe;
  wire logic [7:0] fdata, ewd;
  logic [8:0] ew_seen;
  logic [9:0] expanded_onchip_ram_seen;
  logic [7:0] hi_seen;
  logic [8:0] xe;
  logic [7:0] sq[$];
  logic [8:0] xq[$];
  int failures = 0, checks = 0, n_lat, n_fet, n_fv, n_rd, n_wr, n_expanded_onchip_ram, seed = 76;

  ebme_bus_ctrl ebme_bus_ctrl_i (.core_clk(core_clk), .rstn(rstn), .rst_pin(rst_pin),
    .external_code_select_n(code_sel_n), .code_fetch_strobe_n_i(fet_oe ? fet_o : fetch_drv),
    .code_fetch_strobe_n_o(fet_o), .code_fetch_strobe_n_oe(fet_oe),
    .latch_strobe_i(lat_oe ? lat_o : program_pulse_n_drv), .latch_strobe_o(lat_o), .latch_strobe_oe(lat_oe),
    .rd_strobe_n(rd_n), .wr_strobe_n(wr_n), .addr_hi(addr_hi), .mux_bus_i(mux_oe ? mux_o : mem_drive),
    .mux_bus_o(mux_o), .mux_bus_oe(mux_oe), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(rdata), .sfr_hit(hit), .security_lock4(lock4), .pc(pc),
    .xmove_req(req), .xmove_write(wr), .xmove_use_wide_data_pointer(dp), .xmove_ri_addr(ri), .xmove_wdata(wdata),
    .xmove_done(done), .xmove_rdata(xrdata), .fetch_data(fdata), .fetch_valid(fv), .expanded_onchip_ram_req(expanded_onchip_ram_req),
    .expanded_onchip_ram_we(ewe), .expanded_onchip_ram_addr(expanded_onchip_ram_addr), .expanded_onchip_ram_wdata(ewd), .device_reset(dev_rst), .host_mode(host),
    .program_pulse_n(program_pulse_n_n));

  ebme_ext_mem ebme_ext_mem_i (.core_clk(core_clk), .latch_strobe_o(lat_o), .rd_strobe_n(rd_n),
    .wr_strobe_n(wr_n), .code_fetch_strobe_n_o(fet_o), .mux_bus_o(mux_o), .mux_bus_oe(mux_oe),
    .mem_drive(mem_drive));

  // Free-running oscillator
  always #10 core_clk = ~core_clk;

  // --------------------
  // Checking tasks
  // --------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Watcher: edge counts, and queued notes compared as results appear
  always @(negedge core_clk) begin
    if (lat_o && !p_lat) n_lat++;
    if (!fet_o && p_fet) n_fet++;
    p_lat = lat_o;
    p_fet = fet_o;
    n_rd += int'(!rd_n);
    n_wr += int'(!wr_n);
    n_fv += int'(fv === 1'b1);
    if (!rd_n) hi_seen = addr_hi;
    if (expanded_onchip_ram_req === 1'b1) begin
      n_expanded_onchip_ram++;
      expanded_onchip_ram_seen = expanded_onchip_ram_addr;
      ew_seen = {ewe, ewd};
    end
    if (!rd_n && !wr_n) chk(16'h0001, 16'h0000);
    if (hit === 1'b1) chk(16'(rdata), 16'(sq.pop_front()));
    if (done === 1'b1) begin
      xe = xq.pop_front();
      if (xe[8]) chk(16'(xrdata), 16'(xe[7:0]));
    end
  end

  // --------------------
  // Drivers
  // --------------------
  task automatic sfr_w(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge core_clk);
    sfr_wr = 1'b0;
    @(negedge core_clk);
  endtask

  // Mapped reads queue their note; an unmapped one must answer zero
  task automatic sfr_r(input logic [7:0] a, input logic [7:0] e, input logic m);
    if (m) sq.push_back(e);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge core_clk);
    sfr_rd = 1'b0;
    if (!m) chk(16'({hit, rdata}), 16'h0000);
    @(negedge core_clk);
  endtask

  // One data move, held until done, then strobe and side-RAM counts
  task automatic move(input logic w_i, input logic dp_i, input logic [7:0] ri_i, input logic ext,
                      input logic [9:0] ea, input logic [7:0] e);
    int k;
    xq.push_back({!w_i && ext, e});
    n_rd = 0;
    n_wr = 0;
    n_expanded_onchip_ram = 0;
    wr = w_i;
    dp = dp_i;
    ri = ri_i;
    wdata = e;
    req = 1'b1;
    for (k = 0; k < 40 && done !== 1'b1; k++) @(negedge core_clk);
    req = 1'b0;
    if (k == 40) begin
      failures++;
      end_of_test();
    end
    @(negedge core_clk);
    chk(16'(n_rd), (ext && !w_i) ? 16'h0003 : 16'h0000);
    chk(16'(n_wr), (ext && w_i) ? 16'h0003 : 16'h0000);
    chk(16'(n_expanded_onchip_ram), ext ? 16'h0000 : 16'h0001);
    if (!ext) chk(16'(expanded_onchip_ram_seen), 16'(ea));
    if (!ext) chk(16'(ew_seen), 16'({w_i, e}));
  endtask

  // Counts latch and fetch pulses over five machine cycles
  task automatic window(input int lat, input int fet);
    n_lat = 0;
    n_fet = 0;
    n_fv = 0;
    repeat (60) @(negedge core_clk);
    chk(16'(n_lat), 16'(lat));
    chk(16'(n_fet), 16'(fet));
    chk(16'(n_fv), 16'(fet));
  endtask

  // --------------------
  // Main sequence
  // --------------------
  initial begin
    repeat (6) @(negedge core_clk);
    rstn = 1'b1;
    repeat (4) @(negedge core_clk);
    pc = 16'($random(seed));
    w = 8'($random(seed));
    sfr_r(PTR_LOW_OFS, 8'h00, 1'b1);
    sfr_r(AUX_CTRL_OFS, 8'h00, 1'b1);
    sfr_w(AUX_CTRL_OFS, 8'hFF);
    sfr_w(AUX_CTRL_TWO_OFS, 8'hFF);
    sfr_w(PTR_LOW_OFS, w);
    sfr_r(AUX_CTRL_OFS, 8'h03, 1'b1);
    sfr_r(AUX_CTRL_TWO_OFS, 8'h09, 1'b1);
    sfr_r(PTR_LOW_OFS, w, 1'b1);
    sfr_r(8'h90, 8'h00, 1'b0);
    sfr_w(AUX_CTRL_OFS, 8'h01);
    repeat (12) @(negedge core_clk);
    window(0, 0);
    chk(16'(lat_oe), 16'h0000);
    sfr_w(AUX_CTRL_OFS, 8'h00);
    $display("registers and strobe-off done");
    repeat (12) @(negedge core_clk);
    window(10, 0);
    code_sel_n = 1'b0;
    repeat (12) @(negedge core_clk);
    window(10, 10);
    chk(16'(fdata), 16'(pc[7:0] ^ 8'hA5));
    lock4 = 1'b1;
    repeat (12) @(negedge core_clk);
    window(10, 0);
    lock4 = 1'b0;
    code_sel_n = 1'b1;
    repeat (12) @(negedge core_clk);
    $display("strobe rates done");
    sfr_w(PTR_HIGH_OFS, 8'h03);
    sfr_w(PTR_LOW_OFS, 8'h00);
    move(1'b0, 1'b1, 8'h00, 1'b1, 10'h000, 8'hA5);
    chk(16'(hi_seen), 16'h0003);
    sfr_w(PTR_HIGH_OFS, 8'h02);
    sfr_w(PTR_LOW_OFS, 8'hFF);
    move(1'b0, 1'b1, 8'h00, 1'b0, 10'h2FF, 8'h00);
    move(1'b1, 1'b0, 8'h40, 1'b0, 10'h040, w);
    sfr_w(AUX_CTRL_OFS, 8'h02);
    move(1'b1, 1'b0, 8'h40, 1'b1, 10'h000, w);
    move(1'b0, 1'b0, 8'h40, 1'b1, 10'h000, w);
    move(1'b0, 1'b1, 8'h00, 1'b1, 10'h000, 8'h5A);
    sfr_w(AUX_CTRL_OFS, 8'h00);
    $display("data moves done");
    rst_pin = 1'b1;
    repeat (10) @(negedge core_clk);
    rst_pin = 1'b0;
    repeat (10) @(negedge core_clk);
    chk(16'(dev_rst), 16'h0000);
    rst_pin = 1'b1;
    repeat (40) @(negedge core_clk);
    chk(16'(dev_rst), 16'h0001);
    rst_pin = 1'b0;
    repeat (10) @(negedge core_clk);
    chk(16'({dev_rst, host}), 16'h0000);
    window(10, 0);
    $display("reset pin done");
    rst_pin = 1'b1;
    repeat (140) @(negedge core_clk);
    fetch_drv = 1'b0;
    repeat (10) @(negedge core_clk);
    chk(16'(host), 16'h0000);
    rst_pin = 1'b0;
    repeat (10) @(negedge core_clk);
    chk(16'(host), 16'h0001);
    program_pulse_n_drv = 1'b0;
    repeat (6) @(negedge core_clk);
    chk(16'(program_pulse_n_n), 16'h0000);
    program_pulse_n_drv = 1'b1;
    repeat (6) @(negedge core_clk);
    chk(16'(program_pulse_n_n), 16'h0001);
    $display("host mode done");
    end_of_test();
  end
endmodule
`default_nettype wire
